// file: logic/raster_host.sv
// Host controller that programs a raster video timing generator.
// Assumes the generator accepts one indexed parameter write per clock.
//
// How it works
// RL1: Line timing counts four-pixel screen units.
// RL2: Line period must be even.
// RL3: Sync pulse is two half-sync widths.
// RL4: Display length is pixels divided by four.
// RL5: Front porch implied by remaining line time.
// RL6: Half-line point within display, after porch.
// RL7: Short and broad used in flyback.
// RL8: Interlace odd lines give short lines.
// RL9: Serrated sync lows last broad length.
// RL10: Always program short and broad.
// RL11: Sync low broad, then high porch.
// RL12: Vertical counts half lines, active doubled.
// RL13: Frame holds even number of half lines.
// RL14: Equalisation intervals equal vertical sync.
// RL15: Blank is total minus three syncs.
// RL16: Preload plus lead within 512 bits; not checked when the external mux is selected.
// RL17: Smaller sum allowed for panning.
// RL18: Add one lead unit when unsynchronised.
// RL19: Lead below back porch and short.
// RL20: Pointer selects first line bitmap start.
// RL21: Byte-linear bitmap needs zero serial start.
// RL22: Serial start at most 512 minus lead.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module raster_host
	import raster_host_pkg::*;
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic [AW-1:0]     addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rdata_out,
	output logic      [IDX_W-1:0]  dev_addr_out,
	output logic      [PTR_W-1:0]  dev_data_out,
	output logic                   dev_wr_out
);
	// -----------------------------------------------------------------
	// Software registers
	// -----------------------------------------------------------------
	logic [PW-1:0]    halfsync_q;    // Half sync width
	logic [PW-1:0]    backporch_q;   // Back porch
	logic [PW-1:0]    pixels_q;      // Visible pixels per line
	logic [PW-1:0]    linetime_q;    // Line period
	logic [PW-1:0]    shortdisp_q;   // Short display length
	logic [PW-1:0]    broad_q;       // Broad pulse length
	logic [PW-1:0]    vsync_q;       // Vertical sync half lines
	logic [PW-1:0]    blanktot_q;    // Total blanked half lines
	logic [PW-1:0]    lines_q;       // Displayed lines
	logic [PW-1:0]    preload_q;     // Shift preload length
	logic [PW-1:0]    lead_q;        // Transfer lead length
	logic [PTR_W-1:0] topptr_q;      // Top-of-screen pointer
	logic             async_q;       // Clocks unsynchronised
	logic             extmux_q;      // External serial mux
	logic             linear_q;      // Byte-linear bitmap
	logic             done_q;        // Sticky load finished
	logic             refuse_q;      // Sticky go refused
	logic [31:0]      rdata_q;       // Read data

	// Helper wires
	logic             go;            // Go write seen
	logic             start;         // Go accepted
	logic             busy;          // Writer active
	logic             wr_done;       // Writer finished pulse
	logic [PW-1:0]    frame_blank_halflines;
	logic [PW-1:0]    frame_active_halflines;
	logic [PW-1:0]    transfer_lead_len;

	vtg_param_if p ();

	// -----------------------------------------------------------------
	// Register writes, ignored while a load is running
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			halfsync_q  <= '0;
			backporch_q <= '0;
			pixels_q    <= '0;
			linetime_q  <= '0;
			shortdisp_q <= '0;
			broad_q     <= '0;
			vsync_q     <= '0;
			blanktot_q  <= '0;
			lines_q     <= '0;
			preload_q   <= '0;
			lead_q      <= '0;
			topptr_q    <= '0;
			async_q     <= 1'b0;
			extmux_q    <= 1'b0;
			linear_q    <= 1'b0;
		end else if (wr_in && !busy) begin
			case (addr_in)
				R_HALFSYNC:  halfsync_q  <= wdata_in[PW-1:0];
				R_BACKPORCH: backporch_q <= wdata_in[PW-1:0];
				R_PIXELS:    pixels_q    <= wdata_in[PW-1:0];
				R_LINETIME:  linetime_q  <= wdata_in[PW-1:0];
				R_SHORTDISP: shortdisp_q <= wdata_in[PW-1:0];
				R_BROAD:     broad_q     <= wdata_in[PW-1:0];
				R_VSYNC:     vsync_q     <= wdata_in[PW-1:0];
				R_BLANKTOT:  blanktot_q  <= wdata_in[PW-1:0];
				R_LINES:     lines_q     <= wdata_in[PW-1:0];
				R_PRELOAD:   preload_q   <= wdata_in[PW-1:0];
				R_LEAD:      lead_q      <= wdata_in[PW-1:0];
				R_TOPPTR:    topptr_q    <= wdata_in[PTR_W-1:0];
				R_CTRL: begin
					async_q  <= wdata_in[C_ASYNC];
					extmux_q <= wdata_in[C_EXTMUX];
					linear_q <= wdata_in[C_LINEAR];
				end
				default: begin
					// Unmapped or read-only, ignored
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Derived parameter set
	// -----------------------------------------------------------------
	assign go = wr_in && addr_in == R_CTRL && wdata_in[C_GO];
	assign start = go && !busy && p.err == '0;

	always_comb begin
		// RL15 blank from total less three syncs
		frame_blank_halflines  = blanktot_q - PW'(EQ_PARTS) * vsync_q;
		// RL12 active half lines doubled
		frame_active_halflines = {lines_q[PW-2:0], 1'b0};
		// RL18 margin for unsynchronised clocks
		transfer_lead_len      = async_q ? lead_q + LEAD_MARGIN : lead_q;
	end

	always_comb begin
		p.val[P_HALFSYNC]  = halfsync_q;
		p.val[P_BACKPORCH] = backporch_q;
		// RL4 pixels to screen units
		p.val[P_DISPLAY]   = pixels_q >> SU_SHIFT;
		p.val[P_LINETIME]  = linetime_q;
		p.val[P_SHORTDISP] = shortdisp_q;
		p.val[P_BROAD]     = broad_q;
		p.val[P_VSYNC]     = vsync_q;
		p.val[P_BLANK]     = frame_blank_halflines;
		p.val[P_ACTIVE]    = frame_active_halflines;
		p.val[P_PRELOAD]   = preload_q;
		p.val[P_LEAD]      = transfer_lead_len;
		// RL14 equalisation equals sync
		p.val[P_PRE_EQ]    = vsync_q;
		p.val[P_POST_EQ]   = vsync_q;
		// RL21 linear bitmap, zero serial start
		p.top_ptr = topptr_q;
		if (linear_q) begin
			p.top_ptr[SAM_W-1:0] = '0;
		end
	end

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	vtg_param_check u_check (
		.ext_mux_in (extmux_q),
		.p          (p.chk)
	);

	vtg_param_writer u_writer (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.start_in     (start),
		.p            (p.wr),
		.dev_addr_out (dev_addr_out),
		.dev_data_out (dev_data_out),
		.dev_wr_out   (dev_wr_out),
		.busy_out     (busy),
		.done_out     (wr_done)
	);

	// -----------------------------------------------------------------
	// Sticky status, set wins over clear
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			done_q <= 1'b0;
		end else if (wr_done) begin
			done_q <= 1'b1;
		end else if (go) begin
			done_q <= 1'b0;
		end
	end

	// Refusal flag follows each go outside a load
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			refuse_q <= 1'b0;
		end else if (go && !busy) begin
			refuse_q <= (p.err != '0);
		end
	end

	// -----------------------------------------------------------------
	// Read port, data one cycle after the strobe
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_q <= '0;
		end else if (rd_in) begin
			case (addr_in)
				R_HALFSYNC:  rdata_q <= 32'(halfsync_q);
				R_BACKPORCH: rdata_q <= 32'(backporch_q);
				R_PIXELS:    rdata_q <= 32'(pixels_q);
				R_LINETIME:  rdata_q <= 32'(linetime_q);
				R_SHORTDISP: rdata_q <= 32'(shortdisp_q);
				R_BROAD:     rdata_q <= 32'(broad_q);
				R_VSYNC:     rdata_q <= 32'(vsync_q);
				R_BLANKTOT:  rdata_q <= 32'(blanktot_q);
				R_LINES:     rdata_q <= 32'(lines_q);
				R_PRELOAD:   rdata_q <= 32'(preload_q);
				R_LEAD:      rdata_q <= 32'(lead_q);
				R_TOPPTR:    rdata_q <= 32'(topptr_q);
				R_CTRL:      rdata_q <= 32'({linear_q, extmux_q, async_q, 1'b0});
				R_STATUS:    rdata_q <= 32'({p.err, 5'h00, refuse_q, done_q, busy});
				default:     rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign rdata_out = rdata_q;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	refused_go_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL22
		go && !busy && p.err != '0 |=> !dev_wr_out [*3])
		else $error("load started with failing checks");
	lead_margin_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL18
		start && async_q ##12 dev_wr_out && dev_addr_out == P_LEAD |->
			dev_data_out == PTR_W'($past(lead_q, 12) + LEAD_MARGIN))
		else $error("lead margin not applied");
	eq_match_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL14
		dev_wr_out && dev_addr_out == P_POST_EQ |->
			dev_data_out == $past(dev_data_out) && $past(dev_addr_out) == P_PRE_EQ)
		else $error("equalisation differs from pre value");
	linear_ptr_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL21
		dev_wr_out && dev_addr_out == P_TOPPTR && $past(linear_q) |->
			dev_data_out[SAM_W-1:0] == '0)
		else $error("linear pointer has serial offset");
	done_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
		wr_done |=> done_q)
		else $error("done flag missed");
endmodule

// file: logic/raster_host_pkg.sv
// Constants shared by the raster timing host controller and its helpers.
// Assumes one 25 MHz clock domain and a synchronous active-high reset.
package raster_host_pkg;
	// -----------------------------------------------------------------
	// Widths
	// -----------------------------------------------------------------
	localparam int PW       = 12;            // Timing parameter width
	localparam int PTR_W    = 24;            // Top-of-screen pointer width
	localparam int SAM_W    = 9;             // Serial start address bits of the pointer
	localparam int AW       = 8;             // Software port address width
	localparam int N_PARAMS = 14;            // Parameters sent per load
	localparam int IDX_W    = 4;             // Device parameter index width
	localparam int N_ERR    = 8;             // Consistency checks

	// -----------------------------------------------------------------
	// Arithmetic constants
	// -----------------------------------------------------------------
	localparam int             SU_SHIFT  = 2;      // Four pixels per screen unit
	localparam logic [13:0]    SR_LEN    = 14'h0200; // Serial register length 512
	localparam logic [PW-1:0]  LEAD_MARGIN = 12'h001; // Extra unit, clocks unsynchronised
	localparam int             EQ_PARTS  = 3;      // Pre-eq, sync, post-eq

	// -----------------------------------------------------------------
	// Software register byte addresses
	// -----------------------------------------------------------------
	localparam logic [AW-1:0] R_HALFSYNC  = 8'h00;
	localparam logic [AW-1:0] R_BACKPORCH = 8'h04;
	localparam logic [AW-1:0] R_PIXELS    = 8'h08;
	localparam logic [AW-1:0] R_LINETIME  = 8'h0C;
	localparam logic [AW-1:0] R_SHORTDISP = 8'h10;
	localparam logic [AW-1:0] R_BROAD     = 8'h14;
	localparam logic [AW-1:0] R_VSYNC     = 8'h18;
	localparam logic [AW-1:0] R_BLANKTOT  = 8'h1C;
	localparam logic [AW-1:0] R_LINES     = 8'h20;
	localparam logic [AW-1:0] R_PRELOAD   = 8'h24;
	localparam logic [AW-1:0] R_LEAD      = 8'h28;
	localparam logic [AW-1:0] R_TOPPTR    = 8'h2C;
	localparam logic [AW-1:0] R_CTRL      = 8'h30;
	localparam logic [AW-1:0] R_STATUS    = 8'h34;

	// -----------------------------------------------------------------
	// Control and status fields
	// -----------------------------------------------------------------
	localparam int C_GO     = 0;             // Write 1: validate and load
	localparam int C_ASYNC  = 1;             // Host and video clocks unsynchronised
	localparam int C_EXTMUX = 2;             // External mux lengthens serial register
	localparam int C_LINEAR = 3;             // Byte-linear bitmap wanted
	localparam int S_BUSY   = 0;
	localparam int S_DONE   = 1;             // Sticky, cleared by a go write
	localparam int S_REFUSE = 2;             // Sticky, last go had errors
	localparam int S_ERR_LO = 8;             // Live check results from here

	// -----------------------------------------------------------------
	// Check result bits
	// -----------------------------------------------------------------
	localparam int E_ZERO     = 0;           // Some parameter is zero
	localparam int E_ODD_LINE = 1;           // Line period odd
	localparam int E_HALFLINE = 2;           // Half-line point misplaced
	localparam int E_ODD_FRM  = 3;           // Odd half lines per frame
	localparam int E_BLANK    = 4;           // Blank not whole lines or negative
	localparam int E_SR_LEN   = 5;           // Preload plus lead too long
	localparam int E_LEAD     = 6;           // Lead not below porch or short line
	localparam int E_SAM      = 7;           // Serial start too high

	// -----------------------------------------------------------------
	// Device parameter indices, also the send order
	// -----------------------------------------------------------------
	localparam logic [IDX_W-1:0] P_HALFSYNC  = 4'h0;
	localparam logic [IDX_W-1:0] P_BACKPORCH = 4'h1;
	localparam logic [IDX_W-1:0] P_DISPLAY   = 4'h2;
	localparam logic [IDX_W-1:0] P_LINETIME  = 4'h3;
	localparam logic [IDX_W-1:0] P_SHORTDISP = 4'h4;
	localparam logic [IDX_W-1:0] P_BROAD     = 4'h5;
	localparam logic [IDX_W-1:0] P_VSYNC     = 4'h6;
	localparam logic [IDX_W-1:0] P_BLANK     = 4'h7;
	localparam logic [IDX_W-1:0] P_ACTIVE    = 4'h8;
	localparam logic [IDX_W-1:0] P_PRELOAD   = 4'h9;
	localparam logic [IDX_W-1:0] P_LEAD      = 4'hA;
	localparam logic [IDX_W-1:0] P_PRE_EQ    = 4'hB;
	localparam logic [IDX_W-1:0] P_POST_EQ   = 4'hC;
	localparam logic [IDX_W-1:0] P_TOPPTR    = 4'hD;

	// Writer states
	typedef enum logic [2:0] {
		W_IDLE = 3'b001,
		W_SEND = 3'b010,
		W_DONE = 3'b100
	} wr_state_t;
endpackage

// file: logic/vtg_param_check.sv
// Combinational consistency checks on the derived timing parameters.
// Assumes the parameter set is held stable by the top while in use.
`timescale 1ns/1ps
module vtg_param_check
	import raster_host_pkg::*;
(
	input  wire logic       ext_mux_in,
	vtg_param_if.chk        p
);
	// -----------------------------------------------------------------
	// Wide working copies
	// -----------------------------------------------------------------
	logic [13:0] sync_bp;     // Twice half sync plus back porch
	logic [13:0] to_disp_end; // Sync, porch and display
	logic [13:0] half_line;   // Half the line period
	logic [13:0] frame_hl;    // Half lines per frame
	logic [13:0] sr_use;      // Preload plus lead
	logic [13:0] sam_start;   // Serial start address
	logic        any_zero;    // Some parameter zero

	// Sums for the checks
	always_comb begin
		sync_bp     = 14'({p.val[P_HALFSYNC], 1'b0}) + 14'(p.val[P_BACKPORCH]);
		to_disp_end = sync_bp + 14'(p.val[P_DISPLAY]);
		half_line   = 14'(p.val[P_LINETIME] >> 1);
		frame_hl    = 14'(p.val[P_ACTIVE]) + 14'(p.val[P_BLANK])
			+ 14'(EQ_PARTS) * 14'(p.val[P_VSYNC]);
		sr_use      = 14'(p.val[P_PRELOAD]) + 14'(p.val[P_LEAD]);
		sam_start   = 14'(p.top_ptr[SAM_W-1:0]);
		any_zero    = 1'b0;
		for (int i = 0; i < N_PARAMS - 1; i++) begin
			if (p.val[i] == '0) begin
				any_zero = 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Check results
	// -----------------------------------------------------------------
	always_comb begin
		p.err = '0;
		p.err[E_ZERO] = any_zero;
		// RL2 even line period
		p.err[E_ODD_LINE] = p.val[P_LINETIME][0];
		// RL6 half-line inside display
		p.err[E_HALFLINE] = !(sync_bp < half_line && half_line < to_disp_end);
		// RL13 even half lines per frame
		p.err[E_ODD_FRM] = frame_hl[0];
		// RL15 blank whole lines, not negative
		p.err[E_BLANK] = p.val[P_BLANK][0] || p.val[P_BLANK][PW-1];
		// RL16 serial register length, RL17 shorter is a pan
		p.err[E_SR_LEN] = !ext_mux_in && (sr_use > SR_LEN);
		// RL19 lead below porch and short line
		p.err[E_LEAD] = !(p.val[P_LEAD] < p.val[P_BACKPORCH]
			&& p.val[P_LEAD] < p.val[P_SHORTDISP]);
		// RL22 serial start bound
		p.err[E_SAM] = sam_start > (SR_LEN - 14'(p.val[P_LEAD]));
	end
endmodule

// file: logic/vtg_param_if.sv
// Derived timing parameters passed from the host top to its helpers.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface vtg_param_if;
	import raster_host_pkg::*;
	logic [PW-1:0]    val [N_PARAMS-1]; // Parameters 0..12 in send order
	logic [PTR_W-1:0] top_ptr;          // Pointer, sent last
	logic [N_ERR-1:0] err;              // Check results

	modport src (output val, output top_ptr, input err);
	modport chk (input val, input top_ptr, output err);
	modport wr  (input val, input top_ptr);
endinterface

// file: logic/vtg_param_writer.sv
// Sends the full parameter set to the timing generator, one per cycle.
// Assumes the device takes one parameter write per clock without waiting.
`timescale 1ns/1ps
module vtg_param_writer
	import raster_host_pkg::*;
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic              start_in,   // Accepted load request
	vtg_param_if.wr                p,
	output logic [IDX_W-1:0]       dev_addr_out,
	output logic [PTR_W-1:0]       dev_data_out,
	output logic                   dev_wr_out,
	output logic                   busy_out,
	output logic                   done_out     // One-cycle pulse
);
	wr_state_t        state_q;   // Sequencer state
	logic [IDX_W-1:0] idx_q;     // Next index to send

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_q <= W_IDLE;
		end else begin
			case (state_q)
				W_IDLE: begin
					if (start_in) begin
						state_q <= W_SEND;
					end
				end
				W_SEND: begin
					if (idx_q == P_TOPPTR) begin
						state_q <= W_DONE;
					end
				end
				W_DONE: begin
					state_q <= W_IDLE;
				end
				default: begin
					state_q <= W_IDLE;
				end
			endcase
		end
	end

	// Index walks through every parameter
	always_ff @(posedge core_clk_in) begin
		if (rst_in || state_q != W_SEND) begin
			idx_q <= P_HALFSYNC;
		end else begin
			idx_q <= idx_q + 4'h1;
		end
	end

	// -----------------------------------------------------------------
	// Device write port, registered
	// -----------------------------------------------------------------
	// RL10 always send short and broad
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			dev_wr_out   <= 1'b0;
			dev_addr_out <= '0;
			dev_data_out <= '0;
		end else begin
			dev_wr_out   <= (state_q == W_SEND);
			dev_addr_out <= idx_q;
			if (idx_q == P_TOPPTR) begin
				dev_data_out <= p.top_ptr;
			end else begin
				dev_data_out <= PTR_W'(p.val[idx_q]);
			end
		end
	end

	assign busy_out = (state_q != W_IDLE);
	assign done_out = (state_q == W_DONE);

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence load_start;
		state_q == W_IDLE && start_in;
	endsequence
	sequence load_burst;
		##2 dev_wr_out && dev_addr_out == P_HALFSYNC ##13 dev_wr_out
			&& dev_addr_out == P_TOPPTR ##1 !dev_wr_out;
	endsequence

	load_burst_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
		load_start |-> load_burst)
		else $error("parameter burst not fourteen writes");
	wr_in_send_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
		dev_wr_out |-> $past(state_q) == W_SEND)
		else $error("device write outside send phase");
	addr_step_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
		dev_wr_out && $past(dev_wr_out) |-> dev_addr_out == $past(dev_addr_out) + 4'h1)
		else $error("parameter index skipped");
endmodule

// file: testbench/raster_timing_param_rules_tb.sv
// Self-checking bench for the raster timing host controller.
// Assumes the behavioural generator model sits on the device port.
`timescale 1ns/1ps
module raster_timing_param_rules_tb;
	import raster_host_pkg::*;
	logic             core_clk_in, rst_in, wr_in, rd_in;
	logic [AW-1:0]    addr_in;
	logic [31:0]      wdata_in, rdata_out, st;
	logic [IDX_W-1:0] dev_addr_out;
	logic [PTR_W-1:0] dev_data_out, prm [N_PARAMS];
	logic             dev_wr_out;
	logic [7:0]       cnt, c0;
	logic [PW-1:0]    fp, vsh;
	logic [PW+1:0]    spx;
	int               bad_count, compares;
	logic [31:0] base [12] = '{21, 54, 1280, 422, 109, 205, 6, 74, 1024, 491, 20, 32'h403};

	raster_host uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.dev_addr_out(dev_addr_out), .dev_data_out(dev_data_out), .dev_wr_out(dev_wr_out));
	vtg_device_model dev (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.dev_addr_in(dev_addr_out), .dev_data_in(dev_data_out), .dev_wr_in(dev_wr_out),
		.prm_out(prm), .count_out(cnt), .front_out(fp), .sync_px_out(spx), .vs_high_out(vsh));

	// Clock, 40 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One-cycle register write
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	// Read, data in the following cycle
	task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	// Load the base set with one entry replaced
	task automatic load(input int k, input logic [31:0] v);
		for (int i = 0; i < 12; i++) wr(AW'(4 * i), (i == k) ? v : base[i]);
	endtask
	// Settle options first, then go, then poll busy under a bound
	task automatic go(input logic [31:0] ctrl);
		int n;
		wr(R_CTRL, ctrl);
		wr(R_CTRL, ctrl | 32'h1);
		n = 0;
		do begin
			rd(R_STATUS, st);
			n++;
		end while (st[S_BUSY] !== 1'b0 && n < 40);
		if (st[S_BUSY] !== 1'b0) begin
			bad_count++;
			print_verdict();
		end
	endtask
	task automatic t_reset();
		rd(R_STATUS, st);
		chk({st[E_ZERO + S_ERR_LO], st[2:0]}, 32'h8);
		rd(8'h3C, st);
		chk(st, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_sample();
		load(-1, 0);
		wr(R_CTRL, 32'h2);
		rd(R_STATUS, st);
		chk(st[15:8], 32'h0);
		c0 = cnt;
		go(32'h2);
		chk(st[2:0], 32'h2);
		chk(cnt - c0, 32'hE);
		chk(prm[P_DISPLAY], 32'd320);
		chk(prm[P_SHORTDISP] + prm[P_BROAD], 32'd314);
		chk(prm[P_BLANK], 32'd56);
		chk(prm[P_ACTIVE], 32'd2048);
		chk(prm[P_LEAD] + prm[P_PRELOAD], 32'd512);
		chk({prm[P_PRE_EQ][15:0], prm[P_POST_EQ][15:0]}, {16'd6, 16'd6});
		chk(prm[P_TOPPTR], 32'h403);
		chk(fp, 32'd6);
		chk(spx, 32'd168);
		chk(vsh, 32'd6);
		$display("test sample done");
	endtask
	task automatic t_refuse();
		load(10, 21);
		wr(R_CTRL, 32'h2);
		rd(R_STATUS, st);
		chk(st[15:8], 32'h20);
		c0 = cnt;
		go(32'h2);
		chk({cnt - c0, st[2:0]}, 32'h4);
		go(32'h6);
		chk({cnt - c0, st[2:0]}, 32'h72);
		chk(prm[P_LEAD], 32'd22);
		load(11, 32'h1234);
		go(32'h8);
		chk(prm[P_TOPPTR], 32'h1200);
		chk(prm[P_LEAD], 32'd20);
		rd(R_CTRL, st);
		chk(st, 32'h8);
		$display("test refuse done");
	endtask
	task automatic t_table();
		int k [6] = '{3, 7, 10, 11, 2, 0};
		logic [31:0] v [6] = '{423, 75, 54, 32'h1F0, 400, 0};
		logic [7:0]  m [6] = '{8'h02, 8'h18, 8'h60, 8'h80, 8'h04, 8'h01};
		for (int i = 0; i < 6; i++) begin
			load(k[i], v[i]);
			wr(R_CTRL, 32'h0);
			rd(R_STATUS, st);
			chk(st[15:8], m[i]);
		end
		$display("test table done");
	endtask
	initial begin
		bad_count = 0;
		compares  = 0;
		rst_in    = 1'b1;
		wr_in     = 1'b0;
		rd_in     = 1'b0;
		addr_in   = '0;
		wdata_in  = '0;
		repeat (6) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_sample();
		t_refuse();
		t_table();
		print_verdict();
	end
endmodule

// file: testbench/vtg_device_model.sv
// Behavioural timing generator that keeps each indexed parameter write.
// Assumes the host sends at most one write per clock, never waiting.
`timescale 1ns/1ps
module vtg_device_model
	import raster_host_pkg::*;
(
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic [IDX_W-1:0] dev_addr_in,
	input  wire logic [PTR_W-1:0] dev_data_in,
	input  wire logic             dev_wr_in,
	output logic      [PTR_W-1:0] prm_out [N_PARAMS], // Stored parameters
	output logic      [7:0]       count_out,          // Writes taken
	output logic      [PW-1:0]    front_out,          // Implied front porch
	output logic      [PW+1:0]    sync_px_out,        // Line sync, pixels
	output logic      [PW-1:0]    vs_high_out         // Sync cycle high time
);
	// store each indexed parameter as sent and count the writes
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			count_out <= 8'h00;
		end else if (dev_wr_in) begin
			prm_out[dev_addr_in] <= dev_data_in;
			count_out            <= count_out + 8'h01;
		end
	end
	// no porch parameter, rest of line
	assign front_out = PW'(prm_out[P_LINETIME] - (prm_out[P_HALFSYNC] << 1)
		- prm_out[P_BACKPORCH] - prm_out[P_DISPLAY]);
	// two half syncs, four pixels a unit
	assign sync_px_out = (PW+2)'(prm_out[P_HALFSYNC] << 3);
	assign vs_high_out = PW'((prm_out[P_LINETIME] >> 1) - prm_out[P_BROAD]);
endmodule
